// [testbench/host_term.sv]
// host terminal model: drives the receive line and decodes the transmit line
`timescale 1ns/1ns
module host_term
(
    input  wire logic clk,
    input  wire logic txd,
    output logic      rxd
);
    int         bit_clk = 160;  // clock cycles per bit, set by the bench
    logic [9:0] got_q[$];       // stop ok, parity ok, data
    logic [9:0] f;

    // send one frame; bad_par flips the parity bit to provoke an error
    task automatic send(input logic [7:0] b, input logic bad_par);
        logic [10:0] fr;
        fr = {1'b1, ^b ^ bad_par, b, 1'b0};
        for (int i = 0; i < 11; i++)
        begin
            rxd <= fr[i];
            repeat (bit_clk) @(posedge clk);
        end
    endtask : send

    // sample mid-bit from each start edge; the line idles high like a pulled-up mark
    initial
    begin
        rxd = 1'b1;
        forever
        begin
            @(negedge txd);
            repeat (bit_clk / 2) @(posedge clk);
            for (int i = 0; i < 10; i++)
            begin
                repeat (bit_clk) @(posedge clk);
                f = {txd, f[9:1]};
            end
            got_q.push_back({f[9], ~^f[8:0], f[7:0]});
        end
    end
endmodule : host_term

// [testbench/serial_port_properties.sv]
// concurrent checks on the serial port register bus and line pins
`timescale 1ns/1ns
module serial_port_checker
    import serial_port_pkg::*;
(
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic [4:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] writedata,
    input wire logic [3:0]  byteenable,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    input wire logic [1:0]  rate_switch,
    input wire logic        txd,
    input wire logic        txd_oe_n
);
    logic [2:0] sw_idx;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // rate index the switch should select; only four rates are reachable this way
    assign sw_idx = rate_switch == 2'h0 ? RATE_300 : rate_switch == 2'h1 ? RATE_1200 :
                    rate_switch == 2'h2 ? RATE_9600 : RATE_19200;

    sequence s_one_wait;
        waitrequest ##1 !waitrequest;
    endsequence
    sequence s_ctrl_write;
        write && !waitrequest && address == OFS_CTRL && byteenable[0];
    endsequence
    sequence s_rate_read;
        read && !waitrequest && address == OFS_RATE;
    endsequence

    a_read_one_wait: assert property ($rose(read) |-> s_one_wait)
        else $error("read did not answer after one wait cycle");
    a_write_no_wait: assert property (write && address != OFS_TXDATA |-> !waitrequest)
        else $error("register write stalled");
    a_upper_bits_zero: assert property (read && !waitrequest |-> readdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    a_rate_in_range: assert property (s_rate_read |-> readdata[2:0] != 3'h7)
        else $error("rate index out of range");
    a_switch_rate_map: assert property ((s_rate_read and !readdata[RATE_CMD_BIT])
        |-> readdata[2:0] == sw_idx)
        else $error("switch rate not applied");
    a_oe_follows_ctrl: assert property (s_ctrl_write |=> txd_oe_n ==
        ($past(writedata[CTRL_BUS_MODE]) && !$past(writedata[CTRL_TX_SELECT])))
        else $error("line driver enable wrong after select");
    a_oe_holds: assert property (!(write && address == OFS_CTRL) |=> $stable(txd_oe_n))
        else $error("line driver enable moved without select");
    a_start_bit_low: assert property ($fell(txd) |-> (!txd)[*8])
        else $error("start bit too short");
endmodule : serial_port_checker

bind serial_port_xon_xoff serial_port_checker chk_u (.clk(clk), .resetn(resetn),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .rate_switch(rate_switch), .txd(txd), .txd_oe_n(txd_oe_n));

// [testbench/test_serial_port_xon_xoff.sv]
// self-checking bench of the serial port: registers, frames, flow control, bus mode
`timescale 1ns/1ns
module test_serial_port_xon_xoff
    import serial_port_pkg::*;
;
    logic        clk, resetn, read, write, waitrequest, rxd, txd, txd_oe_n;
    logic [4:0]  address;
    logic [31:0] writedata, readdata, q;
    logic [3:0]  byteenable;
    logic [1:0]  rate_switch;
    int          n_errors, n_checks;

    // 1.6 MHz nominal rate gives 10 cycles a tick, 160 a bit at 9600
    serial_port_xon_xoff #(.CLK_HZ(1600000)) dut_u (.clk(clk), .resetn(resetn),
        .address(address), .read(read), .write(write), .writedata(writedata),
        .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
        .rate_switch(rate_switch), .rxd(rxd), .txd(txd), .txd_oe_n(txd_oe_n));
    // one host port with a single node, well inside the bus's node limit
    host_term host_u (.clk(clk), .txd(txd), .rxd(rxd));

    task automatic stop_test;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : stop_test

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
            n_errors++;
        end
    endtask : chk

    // one avalon transfer; waitrequest and read data are taken as they stand at each rising edge
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                       input logic [3:0] be, output logic [31:0] r);
        logic wt;
        @(posedge clk);
        address <= a;
        writedata <= d;
        byteenable <= be;
        write <= w;
        read <= !w;
        wt = 1'b1;
        for (int n = 0; wt && n < 40000; n++)
        begin
            @(posedge clk);
            wt = waitrequest !== 1'b0;
            r = readdata;
        end
        chk("bus answer", 0, wt);
        write <= 1'b0;
        read <= 1'b0;
    endtask : bus

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'h1, q);
    endtask : wr

    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, 4'h0, q);
        chk("register", e, q);
    endtask : rd

    // bounded wait for frames at the host, then compare each and clear;
    // expecting none still waits longer than one whole frame, so a stray frame shows up
    task automatic host_expect(input logic [7:0] b0, input logic [7:0] b1, input int n);
        for (int k = 0; k < 20000 && (host_u.got_q.size() < n || (n == 0 && k < 2000)); k++)
            @(posedge clk);
        chk("frames", n, host_u.got_q.size());
        if (n > 0) chk("tx byte 0", {22'h0, 2'b11, b0}, host_u.got_q[0]);
        if (n > 1) chk("tx byte 1", {22'h0, 2'b11, b1}, host_u.got_q[1]);
        host_u.got_q.delete();
    endtask : host_expect

    task automatic t_reset;
        rd(OFS_CTRL, 32'h1);
        rd(OFS_RATE, {29'h0, RATE_9600});
        rd(OFS_STATUS, 32'h0);
        rd(5'h14, 32'h0);
    endtask : t_reset

    task automatic t_switch;
        logic [2:0] e [4] = '{RATE_300, RATE_1200, RATE_9600, RATE_19200};
        for (int i = 0; i < 4; i++)
        begin
            rate_switch <= 2'(i);
            rd(OFS_RATE, {29'h0, e[i]});
        end
        rate_switch <= 2'h2;
    endtask : t_switch

    // third write stalls on the full hold until the first frame ends
    task automatic t_tx;
        wr(OFS_TXDATA, 32'ha5);
        wr(OFS_TXDATA, 32'h0f);
        wr(OFS_TXDATA, 32'h80);
        host_expect(8'ha5, 8'h0f, 2);
        host_expect(8'h80, 8'h00, 1);
    endtask : t_tx

    task automatic t_rx;
        host_u.send(8'h3c, 1'b0);
        host_u.send(8'hc3, 1'b0);
        rd(OFS_STATUS, 32'h5);
        rd(OFS_RXDATA, 32'hc3);
        wr(OFS_STATUS, 32'h0e);
        host_u.send(8'h5a, 1'b1);
        rd(OFS_STATUS, 32'h3);
        rd(OFS_RXDATA, 32'h5a);
        wr(OFS_STATUS, 32'h0e);
        rd(OFS_STATUS, 32'h0);
    endtask : t_rx

    task automatic t_xoff;
        host_u.send(CHAR_XOFF, 1'b0);
        rd(OFS_STATUS, 32'h40);
        wr(OFS_TXDATA, 32'h42);
        host_expect(8'h00, 8'h00, 0);
        host_u.send(CHAR_XON, 1'b0);
        host_expect(8'h42, 8'h00, 1);
    endtask : t_xoff

    task automatic t_iface;
        wr(OFS_CTRL, 32'h0);
        host_u.send(8'h77, 1'b0);
        rd(OFS_STATUS, 32'h0);
        wr(OFS_TXDATA, 32'h99);
        host_expect(8'h00, 8'h00, 0);
        wr(OFS_CTRL, 32'h1);
        host_expect(8'h99, 8'h00, 1);
    endtask : t_iface

    task automatic t_bus_mode;
        wr(OFS_CTRL, 32'h3);
        @(negedge clk);
        chk("driver off", 1, txd_oe_n);
        wr(OFS_TXDATA, 32'h66);
        host_expect(8'h00, 8'h00, 0);
        wr(OFS_CTRL, 32'h7);
        @(negedge clk);
        chk("driver on", 0, txd_oe_n);
        host_expect(8'h66, 8'h00, 1);
        wr(OFS_CTRL, 32'h1);
    endtask : t_bus_mode

    // a command-only rate carries a frame: 4800 rounds to 21 cycles a tick
    task automatic t_rate;
        for (int i = 0; i < 7; i++)
        begin
            wr(OFS_RATE, 32'(i));
            rd(OFS_RATE, 32'h8 | 32'(i));
        end
        wr(OFS_RATE, 32'h7);
        rd(OFS_RATE, 32'he);
        bus(1'b1, OFS_RATE, 32'h1, 4'h0, q);
        rate_switch <= 2'h0;
        rd(OFS_RATE, 32'he);
        wr(OFS_RATE, {29'h0, RATE_4800});
        host_u.bit_clk = 336;
        wr(OFS_TXDATA, 32'h3e);
        host_expect(8'h3e, 8'h00, 1);
    endtask : t_rate

    // free-running clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // the whole run is near 30000 cycles; cut it at 100000
    initial
    begin
        #1000000;
        n_errors++;
        stop_test();
    end

    initial
    begin
        n_errors = 0;
        n_checks = 0;
        resetn = 1'b0;
        {read, write, address, writedata, byteenable} = '0;
        rate_switch = 2'h2;
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        t_reset();
        t_switch();
        t_tx();
        t_rx();
        t_xoff();
        t_iface();
        t_bus_mode();
        t_rate();
        stop_test();
    end
endmodule : test_serial_port_xon_xoff

// [verilog/baud_tick_gen.sv]
// bit tick divider: one-cycle enable pulse at sixteen times the selected bit rate
`timescale 1ns/1ns
module baud_tick_gen
    import serial_port_pkg::*;
#(
    parameter int CLK_HZ = CLK_HZ_DEFAULT
)(
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic [2:0] rate_idx,
    output logic            tick
);

    typedef struct packed {
        logic [DIV_W-1:0] cnt;
        logic             tick;
    } div_state_type;

    div_state_type s_r;
    div_state_type s_nxt;

    // both ends use the same divider, so receive and transmit share one rate
    always_comb
    begin
        s_nxt      = s_r;
        s_nxt.tick = 1'b0;
        if (s_r.cnt >= tick_div(rate_idx, CLK_HZ) - DIV_W'(1))
        begin
            s_nxt.cnt  = '0;
            s_nxt.tick = 1'b1;
        end
        else
        begin
            s_nxt.cnt = s_r.cnt + DIV_W'(1);
        end
    end

    // register the divider state
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign tick = s_r.tick;

endmodule : baud_tick_gen

// [verilog/serial_port_pkg.sv]
// shared constants, register map and state types of the serial character port
package serial_port_pkg;

    localparam int        CLK_HZ_DEFAULT = 100_000_000;  // device clock, 10 ns period
    localparam int        OVERSAMPLE     = 16;           // bit ticks per bit period
    localparam int        DIV_W          = 16;
    localparam int        NUM_RATES      = 7;

    // selectable bit rates in bits per second, index 0..6
    localparam int        BAUD_300       = 300;
    localparam int        BAUD_600       = 600;
    localparam int        BAUD_1200      = 1200;
    localparam int        BAUD_2400      = 2400;
    localparam int        BAUD_4800      = 4800;
    localparam int        BAUD_9600      = 9600;
    localparam int        BAUD_19200     = 19200;

    localparam logic [2:0] RATE_300      = 3'h0;
    localparam logic [2:0] RATE_600      = 3'h1;
    localparam logic [2:0] RATE_1200     = 3'h2;
    localparam logic [2:0] RATE_2400     = 3'h3;
    localparam logic [2:0] RATE_4800     = 3'h4;
    localparam logic [2:0] RATE_9600     = 3'h5;
    localparam logic [2:0] RATE_19200    = 3'h6;
    localparam logic [2:0] RATE_RESET    = RATE_9600;    // as delivered

    // flow control characters
    localparam logic [7:0] CHAR_XON      = 8'h11;
    localparam logic [7:0] CHAR_XOFF     = 8'h13;

    // register byte offsets
    localparam logic [4:0] OFS_CTRL      = 5'h00;
    localparam logic [4:0] OFS_RATE      = 5'h04;
    localparam logic [4:0] OFS_TXDATA    = 5'h08;
    localparam logic [4:0] OFS_RXDATA    = 5'h0c;
    localparam logic [4:0] OFS_STATUS    = 5'h10;

    // control field positions and reset values
    localparam int        CTRL_IFACE_ON  = 0;
    localparam int        CTRL_BUS_MODE  = 1;
    localparam int        CTRL_TX_SELECT = 2;
    localparam logic      IFACE_ON_RESET = 1'b1;
    localparam int        RATE_CMD_BIT   = 3;

    // status field positions
    localparam int        ST_RX_VALID    = 0;
    localparam int        ST_PARITY_ERR  = 1;
    localparam int        ST_OVERRUN     = 2;
    localparam int        ST_FRAME_ERR   = 3;
    localparam int        ST_TX_FULL     = 4;
    localparam int        ST_TX_BUSY     = 5;
    localparam int        ST_XOFF        = 6;

    // tick counts within a bit: start bit checked mid-way, later bits a full period on
    localparam logic [3:0] TICK_MID      = 4'h7;
    localparam logic [3:0] TICK_LAST     = 4'hf;
    localparam logic [3:0] LAST_BIT      = 4'h8;          // bits 0..7 data, 8 parity

    typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_type;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_type;

    // clock cycles per bit tick for a rate index, rounded to nearest
    function automatic logic [DIV_W-1:0] tick_div(input logic [2:0] idx, input int clk_hz);
        int baud;
        baud = BAUD_9600;
        case (idx)
            RATE_300:   baud = BAUD_300;
            RATE_600:   baud = BAUD_600;
            RATE_1200:  baud = BAUD_1200;
            RATE_2400:  baud = BAUD_2400;
            RATE_4800:  baud = BAUD_4800;
            RATE_19200: baud = BAUD_19200;
            default:    baud = BAUD_9600;
        endcase
        return DIV_W'((clk_hz + OVERSAMPLE * baud / 2) / (OVERSAMPLE * baud));
    endfunction : tick_div

    // the configuration switch reaches only 300, 1200, 9600 and 19200
    function automatic logic [2:0] switch_rate(input logic [1:0] sw);
        logic [2:0] r;
        r = RATE_9600;
        case (sw)
            2'h0:    r = RATE_300;
            2'h1:    r = RATE_1200;
            2'h2:    r = RATE_9600;
            default: r = RATE_19200;
        endcase
        return r;
    endfunction : switch_rate

endpackage : serial_port_pkg

// [verilog/serial_port_xon_xoff.sv]
// serial character port with even parity, selectable rate, xon/xoff and bus-mode driver
//
// Our own choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ns

// Notes on behaviour
// - frame each character: start bit, data bits, stop bit, equal bit periods
// - transmitter and receiver use one common bit rate
// - receiver realigns its sampling on each character's start bit
// - after the stop bit receiver idles until a new start edge
// - eight data bits, then even parity, then one stop bit
// - rates 300 to 19200 selectable, 9600 by default; here the switch rate applies until a rate is commanded
// - 600, 2400, 4800 only by rate-set command; others also by switch
// - only the active interface acts; others' characters are ignored
// - in bus mode the line driver follows the select command
module serial_port_xon_xoff
    import serial_port_pkg::*;
#(
    parameter int CLK_HZ = CLK_HZ_DEFAULT
)(
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic [4:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic [31:0]      readdata,
    output logic             waitrequest,
    input  wire logic [1:0]  rate_switch,
    input  wire logic        rxd,
    output logic             txd,
    output logic             txd_oe_n
);

    typedef struct packed {
        logic         iface_on;
        logic         bus_mode;
        logic         tx_select;
        logic [2:0]   rate_sel;
        logic         rate_cmd;
        logic [7:0]   tx_hold;
        logic         tx_full;
        tx_state_type tx_state;
        logic [8:0]   tx_shift;
        logic [3:0]   tx_tick;
        logic [3:0]   tx_bit;
        logic         txd;
        logic         xoff;
        rx_state_type rx_state;
        logic         rx_prev;
        logic [3:0]   rx_tick;
        logic [3:0]   rx_bit;
        logic [8:0]   rx_shift;
        logic [7:0]   rx_data;
        logic         rx_valid;
        logic         parity_err;
        logic         overrun;
        logic         frame_err;
        logic [31:0]  readdata;
        logic         rd_done;
    } state_type;

    state_type  s_r;
    state_type  s_nxt;
    logic       tick;
    logic [2:0] rate_eff;
    logic       wr_ok;
    logic       wr_lane0;
    logic       rd_pop;
    logic       tx_allowed;
    logic [7:0] rx_char;

    // command-set rate wins over the switch; the switch cannot reach 600/2400/4800
    assign rate_eff = s_r.rate_cmd ? s_r.rate_sel : switch_rate(rate_switch);

    baud_tick_gen #(
        .CLK_HZ   (CLK_HZ)
    ) u_tick (
        .clk      (clk),
        .resetn   (resetn),
        .rate_idx (rate_eff),
        .tick     (tick)
    );

    // reads take one wait cycle so read data comes from a flip-flop; a full tx hold stalls writes to the tx data register
    assign waitrequest = (read && !s_r.rd_done)
                       || (write && address == OFS_TXDATA && s_r.tx_full);
    assign wr_ok       = write && !waitrequest;
    assign wr_lane0    = wr_ok && byteenable[0];
    assign rd_pop      = read && s_r.rd_done && address == OFS_RXDATA;
    assign tx_allowed  = s_r.iface_on && (!s_r.bus_mode || s_r.tx_select);
    assign rx_char     = s_r.rx_shift[7:0];

    // next-state logic: register bus, transmitter, receiver
    always_comb
    begin
        s_nxt         = s_r;
        s_nxt.rx_prev = rxd;

        // bus read: latch data on the first cycle, release on the second
        s_nxt.rd_done = read && !s_r.rd_done;
        if (read && !s_r.rd_done)
        begin
            s_nxt.readdata = '0;
            case (address)
                OFS_CTRL:
                begin
                    s_nxt.readdata[CTRL_IFACE_ON]  = s_r.iface_on;
                    s_nxt.readdata[CTRL_BUS_MODE]  = s_r.bus_mode;
                    s_nxt.readdata[CTRL_TX_SELECT] = s_r.tx_select;
                end
                OFS_RATE:
                begin
                    s_nxt.readdata[2:0]          = rate_eff;
                    s_nxt.readdata[RATE_CMD_BIT] = s_r.rate_cmd;
                end
                OFS_RXDATA:
                    s_nxt.readdata[7:0] = s_r.rx_data;
                OFS_STATUS:
                begin
                    s_nxt.readdata[ST_RX_VALID]   = s_r.rx_valid;
                    s_nxt.readdata[ST_PARITY_ERR] = s_r.parity_err;
                    s_nxt.readdata[ST_OVERRUN]    = s_r.overrun;
                    s_nxt.readdata[ST_FRAME_ERR]  = s_r.frame_err;
                    s_nxt.readdata[ST_TX_FULL]    = s_r.tx_full;
                    s_nxt.readdata[ST_TX_BUSY]    = s_r.tx_state != TX_IDLE;
                    s_nxt.readdata[ST_XOFF]       = s_r.xoff;
                end
                default:
                    s_nxt.readdata = '0;
            endcase
        end
        if (rd_pop)
            s_nxt.rx_valid = 1'b0;

        // bus write: all fields live in byte lane 0
        if (wr_lane0)
        begin
            case (address)
                OFS_CTRL:
                begin
                    s_nxt.iface_on  = writedata[CTRL_IFACE_ON];
                    s_nxt.bus_mode  = writedata[CTRL_BUS_MODE];
                    s_nxt.tx_select = writedata[CTRL_TX_SELECT];
                end
                OFS_RATE:
                begin
                    // rate-set command: any of the seven rates; bad codes are ignored
                    if (writedata[2:0] < 3'(NUM_RATES))
                    begin
                        s_nxt.rate_sel = writedata[2:0];
                        s_nxt.rate_cmd = 1'b1;
                    end
                end
                OFS_TXDATA:
                begin
                    s_nxt.tx_hold = writedata[7:0];
                    s_nxt.tx_full = 1'b1;
                end
                OFS_STATUS:
                begin
                    if (writedata[ST_PARITY_ERR])
                        s_nxt.parity_err = 1'b0;
                    if (writedata[ST_OVERRUN])
                        s_nxt.overrun = 1'b0;
                    if (writedata[ST_FRAME_ERR])
                        s_nxt.frame_err = 1'b0;
                end
                default:
                    s_nxt.tx_full = s_r.tx_full;
            endcase
        end

        // transmitter: x-off is only looked at between characters
        case (s_r.tx_state)
            TX_IDLE:
            begin
                s_nxt.txd = 1'b1;
                if (tick && s_r.tx_full && !s_r.xoff && tx_allowed)
                begin
                    s_nxt.tx_shift = {^s_r.tx_hold, s_r.tx_hold};
                    s_nxt.tx_full  = 1'b0;
                    s_nxt.txd      = 1'b0;
                    s_nxt.tx_tick  = '0;
                    s_nxt.tx_bit   = '0;
                    s_nxt.tx_state = TX_START;
                end
            end
            TX_START, TX_DATA:
            begin
                if (tick)
                begin
                    s_nxt.tx_tick = s_r.tx_tick + 4'h1;
                    if (s_r.tx_tick == TICK_LAST)
                    begin
                        if (s_r.tx_state == TX_DATA && s_r.tx_bit == LAST_BIT)
                        begin
                            s_nxt.txd      = 1'b1;
                            s_nxt.tx_state = TX_STOP;
                        end
                        else
                        begin
                            s_nxt.tx_bit   = (s_r.tx_state == TX_DATA) ? s_r.tx_bit + 4'h1
                                                                       : 4'h0;
                            s_nxt.txd      = s_r.tx_shift[s_nxt.tx_bit];  // each bit sent once
                            s_nxt.tx_state = TX_DATA;
                        end
                    end
                end
            end
            TX_STOP:
            begin
                if (tick)
                begin
                    s_nxt.tx_tick = s_r.tx_tick + 4'h1;
                    if (s_r.tx_tick == TICK_LAST)
                        s_nxt.tx_state = TX_IDLE;
                end
            end
            default:
                s_nxt.tx_state = TX_IDLE;
        endcase

        // receiver: timing restarts at each falling edge seen while idle, sampled mid-bit
        case (s_r.rx_state)
            RX_IDLE:
            begin
                if (s_r.rx_prev && !rxd)
                begin
                    s_nxt.rx_tick  = '0;
                    s_nxt.rx_bit   = '0;
                    s_nxt.rx_state = RX_START;
                end
            end
            RX_START:
            begin
                if (tick)
                begin
                    s_nxt.rx_tick = s_r.rx_tick + 4'h1;
                    if (s_r.rx_tick == TICK_MID)
                    begin
                        // a pulse gone by mid-bit is noise, not a start bit
                        s_nxt.rx_tick  = '0;
                        s_nxt.rx_state = rxd ? RX_IDLE : RX_DATA;
                    end
                end
            end
            RX_DATA:
            begin
                if (tick)
                begin
                    s_nxt.rx_tick = s_r.rx_tick + 4'h1;
                    if (s_r.rx_tick == TICK_LAST)
                    begin
                        s_nxt.rx_shift = {rxd, s_r.rx_shift[8:1]};
                        s_nxt.rx_bit   = s_r.rx_bit + 4'h1;
                        if (s_r.rx_bit == LAST_BIT)
                            s_nxt.rx_state = RX_STOP;
                    end
                end
            end
            RX_STOP:
            begin
                if (tick)
                begin
                    s_nxt.rx_tick = s_r.rx_tick + 4'h1;
                    if (s_r.rx_tick == TICK_LAST)
                    begin
                        s_nxt.rx_state = RX_IDLE;
                        // characters for an inactive interface are dropped whole
                        if (s_r.iface_on)
                        begin
                            if (!rxd)
                                s_nxt.frame_err = 1'b1;
                            if (^s_r.rx_shift)
                                s_nxt.parity_err = 1'b1;
                            if (rx_char == CHAR_XOFF)
                                s_nxt.xoff = 1'b1;
                            else if (rx_char == CHAR_XON)
                                s_nxt.xoff = 1'b0;
                            else
                            begin
                                // set wins over a read pop in the same cycle
                                if (s_r.rx_valid && !rd_pop)
                                    s_nxt.overrun = 1'b1;
                                s_nxt.rx_data  = rx_char;
                                s_nxt.rx_valid = 1'b1;
                            end
                        end
                    end
                end
            end
            default:
                s_nxt.rx_state = RX_IDLE;
        endcase
    end

    // register the whole state; line idles high, switch rate selected until commanded
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s_r          <= '0;
            s_r.iface_on <= IFACE_ON_RESET;
            s_r.rate_sel <= RATE_RESET;
            s_r.txd      <= 1'b1;
            s_r.rx_prev  <= 1'b1;
            s_r.tx_state <= TX_IDLE;
            s_r.rx_state <= RX_IDLE;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign readdata = s_r.readdata;
    assign txd      = s_r.txd;
    // point-to-point always drives; on the shared bus only the selected node drives
    assign txd_oe_n = s_r.bus_mode && !s_r.tx_select;

endmodule : serial_port_xon_xoff
